// [src/pamx_port_alt_mux.sv]
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "pamx_defs.svh"
module pamx_port_alt_mux #(
    parameter int RX_BIT = 1
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    port0_bit5_pin_in,
    output logic                         port0_bit5_pin_out,
    output logic                         port0_bit5_pin_oe_n,
    output logic                         debug_reset_pulldown_en,
    input  wire logic [15:0]             port3_pin_in,
    output logic [15:0]                  port3_pin_out,
    output logic [15:0]                  port3_pin_oe_n,
    output logic [15:0]                  port3_pullup_en,
    input  wire logic [5:0]              port5_pin_in,
    output logic [5:0]                   port5_pin_out,
    output logic [5:0]                   port5_pin_oe_n,
    input  wire logic                    debug_data_out_pin,
    output pamx_pkg::pamx_debug_type     debug_pins,
    output logic                         debug_activate,
    output pamx_pkg::pamx_alt_type       alt_inputs
);
    if (RX_BIT < 0 || RX_BIT > 15)
        $error("RX_BIT must select a port 3 bit");
    // ==============================
    // helpers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= `PAMX_OFS_PINS);
    endfunction
    // ==============================
    // bus handshake
    // one wait state: pready rises in the second access cycle so read data come from a flop
    logic        sel_q, p0_mode_q, p0_data_q, p0_dir_q;
    logic [15:0] p3_q, pm3_q, pu3_q;
    logic [5:0]  p5_q, pm5_q, pmc5_q, fsa5_q, fsb5_q;
    logic [3:0]  krm_q;
    logic [31:0] rd_d;
    logic        pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic        acc, wr;
    assign acc = psel && penable && pready_q;
    assign wr  = acc && pwrite && mapped(paddr);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped(paddr);
            prdata_q  <= (psel && penable && !pready_q && !pwrite) ? rd_d : 32'h0000_0000;
        end
    end
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign prdata  = prdata_q;
    // ==============================
    // read mux
    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (paddr)
            `PAMX_OFS_DBG:   rd_d[`PAMX_DBG_SEL] = sel_q;
            `PAMX_OFS_P0CTL: rd_d[2:0] = {p0_dir_q, p0_data_q, p0_mode_q};
            `PAMX_OFS_P3:    rd_d[15:0] = p3_q;
            `PAMX_OFS_PM3:   rd_d[15:0] = pm3_q;
            `PAMX_OFS_PU3:   rd_d[15:0] = pu3_q;
            `PAMX_OFS_P3H:   rd_d[7:0] = p3_q[15:8];
            `PAMX_OFS_PORT3_DIRECTION_HIGH_ALIAS:  rd_d[7:0] = pm3_q[15:8];
            `PAMX_OFS_PORT3_PULLUP_HIGH_ALIAS:  rd_d[7:0] = pu3_q[15:8];
            `PAMX_OFS_P5:    rd_d[5:0] = p5_q;
            `PAMX_OFS_PM5:   rd_d[5:0] = pm5_q;
            `PAMX_OFS_PMC5:  rd_d[5:0] = pmc5_q;
            `PAMX_OFS_FSA5:  rd_d[5:0] = fsa5_q;
            `PAMX_OFS_FSB5:  rd_d[5:0] = fsb5_q;
            `PAMX_OFS_KRM:   rd_d[3:0] = krm_q;
            `PAMX_OFS_PINS:
            begin
                rd_d[`PAMX_PINS_P0]        = port0_bit5_pin_in;
                rd_d[`PAMX_PINS_P5 +: 6]  = port5_pin_in;
                rd_d[`PAMX_PINS_P3 +: 16] = port3_pin_in;
            end
            default:         rd_d = 32'h0000_0000;
        endcase
    end
    // ==============================
    // debug and port 0 control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_q                         <= `PAMX_RST_DBG;
            {p0_dir_q, p0_data_q, p0_mode_q} <= `PAMX_RST_P0CTL;
        end
        else if (wr && paddr == `PAMX_OFS_DBG && pstrb[0])
            sel_q <= pwdata[`PAMX_DBG_SEL];
        else if (wr && paddr == `PAMX_OFS_P0CTL && pstrb[0])
        begin
            p0_mode_q <= pwdata[`PAMX_P0_MODE];
            p0_data_q <= pwdata[`PAMX_P0_DATA];
            p0_dir_q  <= pwdata[`PAMX_P0_DIR];
        end
    end
    // ==============================
    // port 3 registers and their high aliases
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            p3_q  <= `PAMX_RST_W16;
            pm3_q <= `PAMX_RST_DIR16;
            pu3_q <= `PAMX_RST_W16;
        end
        else if (wr)
        begin
            case (paddr)
                `PAMX_OFS_P3:  p3_q  <= merge16(p3_q, pwdata, pstrb);
                `PAMX_OFS_PM3: pm3_q <= merge16(pm3_q, pwdata, pstrb);
                `PAMX_OFS_PU3: pu3_q <= merge16(pu3_q, pwdata, pstrb);
                `PAMX_OFS_P3H: p3_q  <= merge16(p3_q, {16'h0000, pwdata[7:0], 8'h00},
                                                {2'b00, pstrb[0], 1'b0});
                `PAMX_OFS_PORT3_DIRECTION_HIGH_ALIAS: pm3_q <= merge16(pm3_q, {16'h0000, pwdata[7:0], 8'h00},
                                                 {2'b00, pstrb[0], 1'b0});
                `PAMX_OFS_PORT3_PULLUP_HIGH_ALIAS: pu3_q <= merge16(pu3_q, {16'h0000, pwdata[7:0], 8'h00},
                                                 {2'b00, pstrb[0], 1'b0});
                default: ;
            endcase
        end
    end
    // ==============================
    // port 5 registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            p5_q   <= `PAMX_RST_W6;
            pm5_q  <= `PAMX_RST_DIR6;
            pmc5_q <= `PAMX_RST_W6;
            fsa5_q <= `PAMX_RST_W6;
            fsb5_q <= `PAMX_RST_W6;
            krm_q  <= `PAMX_RST_KRM;
        end
        else if (wr && pstrb[0])
        begin
            case (paddr)
                `PAMX_OFS_P5:   p5_q   <= pwdata[5:0];
                `PAMX_OFS_PM5:  pm5_q  <= pwdata[5:0];
                `PAMX_OFS_PMC5: pmc5_q <= pwdata[5:0];
                `PAMX_OFS_FSA5: fsa5_q <= pwdata[5:0];
                `PAMX_OFS_FSB5: fsb5_q <= pwdata[5:0];
                `PAMX_OFS_KRM:  krm_q  <= pwdata[3:0];
                default: ;
            endcase
        end
    end
    // ==============================
    // pin multiplexing, all outputs registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port0_bit5_pin_out      <= 1'b0;
            port0_bit5_pin_oe_n     <= 1'b1;
            debug_reset_pulldown_en <= 1'b1;
            debug_pins              <= '0;
            debug_activate          <= 1'b0;
            alt_inputs              <= '0;
        end
        else
        begin
            port0_bit5_pin_out  <= p0_data_q;
            port0_bit5_pin_oe_n <= sel_q || p0_mode_q || p0_dir_q;
            debug_pins.reset    <= sel_q && port0_bit5_pin_in;
            debug_reset_pulldown_en <= sel_q;
            // high reset pin while selected activates debug
            debug_activate <= sel_q && port0_bit5_pin_in;
            debug_pins.data_in     <= sel_q && port5_pin_in[0];
            debug_pins.clock       <= sel_q && port5_pin_in[2];
            debug_pins.mode_select <= sel_q && port5_pin_in[3];
            alt_inputs.ext_interrupt_2_input <= !sel_q && p0_mode_q && port0_bit5_pin_in;
            // shared pin feeds both; software keeps the unused one quiet
            alt_inputs.ext_interrupt_7_input <= port3_pin_in[RX_BIT];
            alt_inputs.serial0_receive_input <= port3_pin_in[RX_BIT];
            for (int i = 0; i < 4; i++)
            begin
                alt_inputs.timer_capture_input[i] <= !sel_q && pmc5_q[i] && fsa5_q[i]
                                                     && port5_pin_in[i];
                alt_inputs.key_return_input[i]    <= !sel_q && pmc5_q[i] && krm_q[i]
                                                     && port5_pin_in[i];
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port3_pin_out   <= 16'h0000;
            port3_pin_oe_n  <= 16'hFFFF;
            port3_pullup_en <= 16'h0000;
            port5_pin_out   <= 6'h00;
            port5_pin_oe_n  <= 6'h3F;
        end
        else
        begin
            port3_pin_out   <= p3_q;
            port3_pin_oe_n  <= pm3_q;
            port3_pullup_en <= pu3_q & pm3_q;
            for (int i = 0; i < 6; i++)
            begin
                port5_pin_out[i]  <= p5_q[i];
                port5_pin_oe_n[i] <= pmc5_q[i] || pm5_q[i];
                // unselected control mode released rather than driven
                if (pmc5_q[i] && !fsa5_q[i] && !fsb5_q[i])
                    port5_pin_oe_n[i] <= 1'b1;
            end
            if (sel_q)
            begin
                port5_pin_oe_n[3:0] <= 4'b1101;
                port5_pin_out[1]    <= debug_data_out_pin;
            end
        end
    end
    // ==============================
    // checks
    sequence s_alias_wr(logic [7:0] ofs);
        wr && paddr == ofs && pstrb[0];
    endsequence
    a_debug_reset_route: assert property (@(posedge pclk) disable iff (!presetn)
        sel_q && $stable(sel_q) |=> debug_pins.reset == $past(port0_bit5_pin_in))
        else $error("debug reset not routed from port 0 bit 5");
    a_data_alias_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_alias_wr(`PAMX_OFS_P3H) |=> p3_q[15:8] == $past(pwdata[7:0]) ##2
        port3_pin_out[15:8] == $past(pwdata[7:0], 3))
        else $error("data alias write missed high byte");
    a_dir_alias_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_alias_wr(`PAMX_OFS_PORT3_DIRECTION_HIGH_ALIAS) |=> pm3_q[15:8] == $past(pwdata[7:0]))
        else $error("direction alias write missed high byte");
    a_pullup_alias_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_alias_wr(`PAMX_OFS_PORT3_PULLUP_HIGH_ALIAS) |=> pu3_q[15:8] == $past(pwdata[7:0]))
        else $error("pull-up alias write missed high byte");
    a_debug_activate_cause: assert property (@(posedge pclk) disable iff (!presetn)
        debug_activate |-> $past(sel_q) && $past(port0_bit5_pin_in))
        else $error("debug activation without cause");
    a_pulldown_follow: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(sel_q) |=> !debug_reset_pulldown_en)
        else $error("pull-down not released after select cleared");
    a_ctrl_unselected: assert property (@(posedge pclk) disable iff (!presetn)
        !sel_q && pmc5_q[4] && fsa5_q[4] == 1'b0 && fsb5_q[4] == 1'b0 |=> port5_pin_oe_n[4])
        else $error("unselected control mode pin driven");
    a_alias_low_kept: assert property (@(posedge pclk) disable iff (!presetn)
        s_alias_wr(`PAMX_OFS_P3H) |=> p3_q[7:0] == $past(p3_q[7:0]))
        else $error("alias write touched low byte");
    a_alias_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready_q && !pwrite && paddr == `PAMX_OFS_PORT3_PULLUP_HIGH_ALIAS
        |=> pready && prdata == {24'h000000, $past(pu3_q[15:8])})
        else $error("alias read not high byte only");
endmodule

// [src/pamx_defs.svh]
`ifndef PAMX_DEFS_SVH
`define PAMX_DEFS_SVH
// ==============================
// register byte offsets
`define PAMX_OFS_DBG     8'h00
`define PAMX_OFS_P0CTL   8'h04
`define PAMX_OFS_P3      8'h08
`define PAMX_OFS_PM3     8'h0C
`define PAMX_OFS_PU3     8'h10
`define PAMX_OFS_P3H     8'h14
`define PAMX_OFS_PORT3_DIRECTION_HIGH_ALIAS    8'h18
`define PAMX_OFS_PORT3_PULLUP_HIGH_ALIAS    8'h1C
`define PAMX_OFS_P5      8'h20
`define PAMX_OFS_PM5     8'h24
`define PAMX_OFS_PMC5    8'h28
`define PAMX_OFS_FSA5    8'h2C
`define PAMX_OFS_FSB5    8'h30
`define PAMX_OFS_KRM     8'h34
`define PAMX_OFS_PINS    8'h38
// ==============================
// field positions
`define PAMX_DBG_SEL     0
`define PAMX_P0_MODE     0
`define PAMX_P0_DATA     1
`define PAMX_P0_DIR      2
`define PAMX_PINS_P0     0
`define PAMX_PINS_P5     8
`define PAMX_PINS_P3     16
// ==============================
// reset values
`define PAMX_RST_DBG     1'b1
`define PAMX_RST_P0CTL   3'h4
`define PAMX_RST_W16     16'h0000
`define PAMX_RST_DIR16   16'hFFFF
`define PAMX_RST_W6      6'h00
`define PAMX_RST_DIR6    6'h3F
`define PAMX_RST_KRM     4'h0
`endif

// [src/pamx_pkg.sv]
package pamx_pkg;
    // debug pins routed from port 0 bit 5 and port 5 bits 0, 2 and 3
    typedef struct packed {
        logic reset;
        logic data_in;
        logic clock;
        logic mode_select;
    } pamx_debug_type;

    // alternate inputs delivered to the peripherals
    typedef struct packed {
        logic       ext_interrupt_2_input;
        logic       ext_interrupt_7_input;
        logic       serial0_receive_input;
        logic [3:0] timer_capture_input;
        logic [3:0] key_return_input;
    } pamx_alt_type;
endpackage

// [tb/pamx_port_alt_mux_tb.sv]
`timescale 1ns/1ps
`include "pamx_defs.svh"
module pamx_port_alt_mux_tb;
    logic                     pclk;
    logic                     presetn;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [7:0]               paddr;
    logic [31:0]              pwdata;
    logic [3:0]               pstrb;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic                     port0_bit5_pin_in;
    logic                     port0_bit5_pin_out;
    logic                     port0_bit5_pin_oe_n;
    logic                     debug_reset_pulldown_en;
    logic [15:0]              port3_pin_in;
    logic [15:0]              port3_pin_out;
    logic [15:0]              port3_pin_oe_n;
    logic [15:0]              port3_pullup_en;
    logic [5:0]               port5_pin_in;
    logic [5:0]               port5_pin_out;
    logic [5:0]               port5_pin_oe_n;
    logic                     debug_data_out_pin;
    pamx_pkg::pamx_debug_type debug_pins;
    logic                     debug_activate;
    pamx_pkg::pamx_alt_type   alt_inputs;
    logic [31:0]              rd;
    logic                     er;
    int                       miscompares;
    int                       checks;

    pamx_port_alt_mux #(.RX_BIT(1)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port0_bit5_pin_in(port0_bit5_pin_in),
        .port0_bit5_pin_out(port0_bit5_pin_out), .port0_bit5_pin_oe_n(port0_bit5_pin_oe_n),
        .debug_reset_pulldown_en(debug_reset_pulldown_en), .port3_pin_in(port3_pin_in),
        .port3_pin_out(port3_pin_out), .port3_pin_oe_n(port3_pin_oe_n),
        .port3_pullup_en(port3_pullup_en), .port5_pin_in(port5_pin_in),
        .port5_pin_out(port5_pin_out), .port5_pin_oe_n(port5_pin_oe_n),
        .debug_data_out_pin(debug_data_out_pin), .debug_pins(debug_pins),
        .debug_activate(debug_activate), .alt_inputs(alt_inputs)
    );

    // ==============================
    // clock, verdict, shared tasks
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic give_verdict;
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1)
        begin
            miscompares++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s);
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hF);
        check(what, rd, exp);
    endtask

    // pin outputs lag a register write by one more edge
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    // ==============================
    // scenarios
    task automatic test_reset;
        rchk("debug select", `PAMX_OFS_DBG, 32'h1);
        rchk("port0 ctrl", `PAMX_OFS_P0CTL, 32'h4);
        rchk("port3 dir", `PAMX_OFS_PM3, 32'hFFFF);
        rchk("port3 pullup", `PAMX_OFS_PU3, 32'h0);
        rchk("key mode", `PAMX_OFS_KRM, 32'h0);
        check("pulldown", 32'(debug_reset_pulldown_en), 32'h1);
        check("p0 oe_n reset", 32'(port0_bit5_pin_oe_n), 32'h1);
        check("activate idle", 32'(debug_activate), 32'h0);
    endtask

    task automatic test_debug;
        // mode bit set yet pin still debug reset
        wreg(`PAMX_OFS_P0CTL, 32'h1, 4'h1);
        port0_bit5_pin_in <= 1'b1;
        settle();
        check("debug reset", 32'(debug_pins.reset), 32'h1);
        check("p0 released", 32'(port0_bit5_pin_oe_n), 32'h1);
        check("int2 blocked", 32'(alt_inputs.ext_interrupt_2_input), 32'h0);
        check("activate", 32'(debug_activate), 32'h1);
        @(posedge pclk);
        port0_bit5_pin_in <= 1'b0;
        port5_pin_in <= 6'h0D;
        debug_data_out_pin <= 1'b1;
        settle();
        check("debug reset low", 32'(debug_pins.reset), 32'h0);
        check("activate low", 32'(debug_activate), 32'h0);
        check("debug port5 in", 32'(debug_pins), 32'h7);
        check("debug port5 oe_n", 32'(port5_pin_oe_n), 32'h3D);
        check("debug port5 out", 32'(port5_pin_out), 32'h02);
        // pin held low until select cleared
        wreg(`PAMX_OFS_DBG, 32'h0, 4'h1);
        settle();
        check("pulldown off", 32'(debug_reset_pulldown_en), 32'h0);
        check("port5 freed out", 32'(port5_pin_out), 32'h00);
        check("port5 freed oe_n", 32'(port5_pin_oe_n), 32'h3F);
        port0_bit5_pin_in <= 1'b1;
        settle();
        check("debug pins off", 32'(debug_pins), 32'h0);
        check("activate off", 32'(debug_activate), 32'h0);
        check("int2 routed", 32'(alt_inputs.ext_interrupt_2_input), 32'h1);
        wreg(`PAMX_OFS_P0CTL, 32'h2, 4'h1);
        settle();
        check("p0 driven", 32'(port0_bit5_pin_oe_n), 32'h0);
        check("p0 out", 32'(port0_bit5_pin_out), 32'h1);
    endtask

    task automatic test_alias;
        logic [7:0]  base [3];
        logic [15:0] bv [3];
        base = '{`PAMX_OFS_P3, `PAMX_OFS_PM3, `PAMX_OFS_PU3};
        bv = '{16'h1234, 16'h560F, 16'h783C};
        for (int i = 0; i < 3; i++)
        begin
            wreg(base[i], {16'h0, bv[i]}, 4'hF);
            // upper write data must not leak past bits 8 to 15
            wreg(base[i] + 8'h0C, 32'hFFFF_FFAB, 4'h1);
            rchk("base via alias", base[i], {16'h0, 8'hAB, bv[i][7:0]});
            rchk("alias read", base[i] + 8'h0C, 32'hAB);
        end
        settle();
        check("port3 out", 32'(port3_pin_out), 32'hAB34);
        check("port3 oe_n", 32'(port3_pin_oe_n), 32'hAB0F);
        check("port3 pullup", 32'(port3_pullup_en), 32'hAB0C);
        apb(1'b1, 8'h15, 32'h0000_0055, 4'h1);
        check("misaligned error", 32'(er), 32'h1);
        rchk("data kept", `PAMX_OFS_P3, 32'hAB34);
        apb(1'b0, 8'h40, 32'h0, 4'hF);
        check("unmapped error", 32'(er), 32'h1);
        check("unmapped data", rd, 32'h0);
    endtask

    task automatic test_pins;
        // receiver assumed off, ext int 7 in use
        @(posedge pclk);
        port3_pin_in <= 16'hA5C3;
        port5_pin_in <= 6'h2A;
        settle();
        check("ext int 7", 32'(alt_inputs.ext_interrupt_7_input), 32'h1);
        check("serial rx", 32'(alt_inputs.serial0_receive_input), 32'h1);
        rchk("pin levels", `PAMX_OFS_PINS, 32'hA5C3_2A01);
        // edge enables kept off while receive follows the pin
        port3_pin_in <= 16'hA5C1;
        settle();
        check("serial rx low", 32'(alt_inputs.serial0_receive_input), 32'h0);
        check("ext int 7 low", 32'(alt_inputs.ext_interrupt_7_input), 32'h0);
    endtask

    task automatic test_port5;
        wreg(`PAMX_OFS_PM5, 32'h2F, 4'h1);
        wreg(`PAMX_OFS_P5, 32'h10, 4'h1);
        settle();
        check("port5 drive", 32'(port5_pin_oe_n), 32'h2F);
        check("port5 data", 32'(port5_pin_out), 32'h10);
        wreg(`PAMX_OFS_PMC5, 32'h10, 4'h1);
        settle();
        check("port5 undefined", 32'(port5_pin_oe_n[4]), 32'h1);
        wreg(`PAMX_OFS_FSA5, 32'h1, 4'h1);
        wreg(`PAMX_OFS_FSB5, 32'h2, 4'h1);
        // key mode only on pin 1
        wreg(`PAMX_OFS_KRM, 32'h2, 4'h1);
        wreg(`PAMX_OFS_PMC5, 32'h13, 4'h1);
        port5_pin_in <= 6'h03;
        settle();
        check("capture", 32'(alt_inputs.timer_capture_input), 32'h1);
        check("key return", 32'(alt_inputs.key_return_input), 32'h2);
    endtask

    // ==============================
    // main sequence and timeout
    initial
    begin
        miscompares = 0;
        checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        port0_bit5_pin_in = 1'b0;
        port3_pin_in = 16'h0000;
        port5_pin_in = 6'h00;
        debug_data_out_pin = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_debug();
        test_alias();
        test_pins();
        test_port5();
        give_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        give_verdict();
    end
endmodule
